/* pkg/unas_pkg.sv */
// Shared constants and types for the user store access sequencer.
// Assumes a single 10 MHz system clock; no bus, all controls are ports.
package unas_pkg;

   // Store geometry
   localparam int USER_BITS = 112;
   localparam int CNT_W = 6;
   localparam int TRIM_W = 16;
   localparam int KEY_W = 20;
   localparam int SECT_W = USER_BITS + CNT_W;

   // Write-cycle ceiling and reset values
   localparam logic [CNT_W-1:0] MAX_WRITES = 6'h20;
   localparam logic [TRIM_W-1:0] TRIM_RESET = 16'h5a3c;

   // Operation select codes and unlock keys
   localparam logic [1:0] OP_ERASE = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h3;
   localparam logic [KEY_W-1:0] KEY_FIRST = 20'h1572f;
   localparam logic [KEY_W-1:0] KEY_SECOND = 20'h1602f;

   // Operation time, longest figure, so cycles round down
   localparam int OP_TIME_US = 10000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int OP_CYCLES = (OP_TIME_US * 1000) / CLK_PERIOD_NS;

   // Check code over counter and user data
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'hff;

   function automatic logic [7:0] crc8(input logic [SECT_W-1:0] d);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = SECT_W - 1; i >= 0; i--) begin
         c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc8

   localparam logic [7:0] CRC_RESET = crc8({SECT_W{1'b0}});

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_KEY1  = 3'b001,
      ST_ERASE = 3'b010,
      ST_WRITE = 3'b011,
      ST_LOAD  = 3'b100,
      ST_HOLD  = 3'b101
   } unas_state_t;

endpackage : unas_pkg

/* verilog/unas_store.sv */
// Nonvolatile user sectors: data, write-cycle counter, check code, trim.
// Assumes one-cycle erase and program strobes from the sequencer.
`timescale 1ns/100ps
module unas_store (
   input wire logic clk_sys, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic erase_en, // Erase user sectors, pulse
   input wire logic prog_en, // Program user sectors, pulse
   input wire logic [unas_pkg::USER_BITS-1:0] prog_data, // Staged data
   output logic [unas_pkg::USER_BITS-1:0] user_q, // Stored user data
   output logic [unas_pkg::CNT_W-1:0] cnt_q, // Stored write count
   output logic [7:0] crc_q, // Stored check code
   output logic [unas_pkg::TRIM_W-1:0] trim_q // Trim sector
);
   logic [unas_pkg::USER_BITS-1:0] user_d;
   logic [unas_pkg::CNT_W-1:0] cnt_d;
   logic [7:0] crc_d;

   // Next sector content; trim is never touched here
   always_comb begin
      user_d = user_q;
      cnt_d = cnt_q;
      crc_d = crc_q;
      if (erase_en) begin
         // Check code erased too, so a read straight after shows an error
         user_d = '0;
         cnt_d = '0;
         crc_d = 8'h00;
      end else if (prog_en) begin
         user_d = user_q | prog_data;
         if (cnt_q != unas_pkg::MAX_WRITES) begin
            cnt_d = cnt_q + 6'h01;
         end
         crc_d = unas_pkg::crc8({cnt_d, user_d});
      end
   end

   // Sector registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         user_q <= '0;
         cnt_q <= '0;
         crc_q <= unas_pkg::CRC_RESET;
         trim_q <= unas_pkg::TRIM_RESET;
      end else begin
         user_q <= user_d;
         cnt_q <= cnt_d;
         crc_q <= crc_d;
         trim_q <= trim_q;
      end
   end

endmodule : unas_store

/* verilog/unas_seq.sv */
// User store access sequencer: read reload, erase and write with unlock.
// Assumes software drives the control ports synchronously to clk_sys.
//
// Notes on behaviour
// - user store holds up to 112 bits, apart from trim data
// - read copies data and counter to readback, reloads trim
// - write programs user sectors from staging, trim untouched
// - programming only sets bits; result is OR with old content
// - erase zeroes all user sectors and counter, trim untouched
// - read downloads once per reload trigger, then waits for its release
// - each download checks stored content; mismatch sets error flag
// - busy flag stays low during read
// - armed erase or write starts after first then second key
// - busy held high during erase or write, low when done
// - each operation completes within 10 ms
// - each write increments counter; at 32 writes are blocked
// - loaded counter above maximum locks erase and write
// - new data visible only after a read reload
`timescale 1ns/100ps
module unas_seq #(
   parameter int OP_CYCLES_P = unas_pkg::OP_CYCLES // Cycles per operation
) (
   input wire logic clk_sys, // System clock, 10 MHz
   input wire logic rst, // Async reset, active high
   input wire logic [unas_pkg::USER_BITS-1:0] store_staging_regs, // Data
   input wire logic [1:0] operation_select, // Erase or write select
   input wire logic program_arm, // Arms erase or write
   input wire logic [unas_pkg::KEY_W-1:0] unlock_key_port, // Key value
   input wire logic unlock_key_wr, // Key write strobe
   input wire logic reload_trigger, // Read download request, level
   output logic [unas_pkg::USER_BITS-1:0] store_readback_regs, // Readback
   output logic [unas_pkg::CNT_W-1:0] write_cycle_counter, // Loaded count
   output logic [unas_pkg::TRIM_W-1:0] trim_readback, // Reloaded trim
   output logic user_crc_err, // Last download failed check
   output logic program_in_progress, // Erase or write running
   output logic store_locked, // Erase and write refused
   output logic op_refused // Key sequence discarded, pulse
);
   localparam int TMR_W = $clog2(OP_CYCLES_P + 1);
   localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(OP_CYCLES_P - 1);

   unas_pkg::unas_state_t state_q, state_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   logic [unas_pkg::USER_BITS-1:0] rdbk_q, rdbk_d;
   logic [unas_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [unas_pkg::TRIM_W-1:0] trim_q, trim_d;
   logic crc_err_q, crc_err_d;
   logic busy_q, busy_d;
   logic lock_q, lock_d;
   logic refused_q, refused_d;
   logic erase_en, prog_en, op_done, armed_op;
   logic [unas_pkg::USER_BITS-1:0] st_user;
   logic [unas_pkg::CNT_W-1:0] st_cnt;
   logic [7:0] st_crc;
   logic [unas_pkg::TRIM_W-1:0] st_trim;

   unas_store u_store (
      .clk_sys(clk_sys),
      .rst(rst),
      .erase_en(erase_en),
      .prog_en(prog_en),
      .prog_data(store_staging_regs),
      .user_q(st_user),
      .cnt_q(st_cnt),
      .crc_q(st_crc),
      .trim_q(st_trim)
   );

   // erase and write need the arm bit with a valid select
   assign armed_op = program_arm && operation_select[1];
   assign op_done = (tmr_q == TMR_LAST);
   // erase commits at the end of its time
   assign erase_en = (state_q == unas_pkg::ST_ERASE) && op_done;
   // write commits at the end of its time
   assign prog_en = (state_q == unas_pkg::ST_WRITE) && op_done;

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      tmr_d = '0;
      refused_d = 1'b0;
      case (state_q)
         unas_pkg::ST_IDLE: begin
            // trigger has priority over a key in the same cycle
            if (reload_trigger) begin
               state_d = unas_pkg::ST_LOAD;
            end else if (unlock_key_wr) begin
               // only an armed first key opens the sequence
               if (armed_op && unlock_key_port == unas_pkg::KEY_FIRST) begin
                  state_d = unas_pkg::ST_KEY1;
               end else begin
                  refused_d = 1'b1;
               end
            end
         end
         unas_pkg::ST_KEY1: begin
            if (!armed_op) begin
               state_d = unas_pkg::ST_IDLE;
            end else if (unlock_key_wr) begin
               state_d = unas_pkg::ST_IDLE;
               // second key in order starts the operation
               if (unlock_key_port != unas_pkg::KEY_SECOND) begin
                  refused_d = 1'b1;
               end else if (lock_q) begin
                  refused_d = 1'b1;
               end else if (operation_select == unas_pkg::OP_ERASE) begin
                  state_d = unas_pkg::ST_ERASE;
               end else if (st_cnt >= unas_pkg::MAX_WRITES) begin
                  refused_d = 1'b1;
               end else begin
                  state_d = unas_pkg::ST_WRITE;
               end
            end
         end
         unas_pkg::ST_ERASE, unas_pkg::ST_WRITE: begin
            tmr_d = tmr_q + 1'b1;
            if (op_done) begin
               state_d = unas_pkg::ST_IDLE;
               tmr_d = '0;
            end
         end
         unas_pkg::ST_LOAD: begin
            state_d = unas_pkg::ST_HOLD;
         end
         unas_pkg::ST_HOLD: begin
            // Wait for release so one trigger gives one download
            if (!reload_trigger) begin
               state_d = unas_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = unas_pkg::ST_IDLE;
         end
      endcase
      // busy mirrors erase or write in progress
      busy_d = (state_d == unas_pkg::ST_ERASE) ||
               (state_d == unas_pkg::ST_WRITE);
   end

   // Sequencer registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= unas_pkg::ST_IDLE;
         tmr_q <= '0;
         busy_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
         busy_q <= busy_d;
         refused_q <= refused_d;
      end
   end

   // Readback image; changes only on a download, never on write
   always_comb begin
      rdbk_d = rdbk_q;
      cnt_d = cnt_q;
      trim_d = trim_q;
      crc_err_d = crc_err_q;
      lock_d = lock_q;
      // readback moves only in the download cycle
      if (state_q == unas_pkg::ST_LOAD) begin
         rdbk_d = st_user;
         cnt_d = st_cnt;
         trim_d = st_trim;
         // whole user sector checked on every download
         crc_err_d = (unas_pkg::crc8({st_cnt, st_user}) != st_crc);
         // an impossible count locks the store until reset
         if (st_cnt > unas_pkg::MAX_WRITES) begin
            lock_d = 1'b1;
         end
      end
   end

   // Readback registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdbk_q <= '0;
         cnt_q <= '0;
         trim_q <= unas_pkg::TRIM_RESET;
         crc_err_q <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         rdbk_q <= rdbk_d;
         cnt_q <= cnt_d;
         trim_q <= trim_d;
         crc_err_q <= crc_err_d;
         lock_q <= lock_d;
      end
   end

   // Outputs straight from flops
   assign store_readback_regs = rdbk_q;
   assign write_cycle_counter = cnt_q;
   assign trim_readback = trim_q;
   assign user_crc_err = crc_err_q;
   assign program_in_progress = busy_q;
   assign store_locked = lock_q;
   assign op_refused = refused_q;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic [TMR_W:0] busy_len_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busy_len_q <= '0;
      end else begin
         busy_len_q <= busy_q ? busy_len_q + 1'b1 : '0;
      end
   end

   busy_follows_op_a : assert property (
      busy_q == (state_q == unas_pkg::ST_ERASE ||
                 state_q == unas_pkg::ST_WRITE))
      else $error("busy flag out of step with operation");
   read_not_busy_a : assert property (
      (state_q == unas_pkg::ST_LOAD || state_q == unas_pkg::ST_HOLD)
      |-> !busy_q)
      else $error("busy raised during read");
   op_time_bound_a : assert property (
      busy_len_q <= (TMR_W + 1)'(OP_CYCLES_P))
      else $error("operation exceeds its time");
   erase_zeroes_a : assert property (
      erase_en |=> st_user == '0 && st_cnt == '0 && $stable(st_trim))
      else $error("erase left user sectors set");
   write_or_a : assert property (
      prog_en |=> st_user == ($past(st_user) | $past(store_staging_regs)))
      else $error("programming cleared a bit");
   write_count_a : assert property (
      prog_en |=> st_cnt == $past(st_cnt) + 6'h01)
      else $error("counter not incremented by write");
   key_start_a : assert property (
      $rose(busy_q) |-> $past(state_q) == unas_pkg::ST_KEY1 &&
      $past(unlock_key_wr) && $past(unlock_key_port) == unas_pkg::KEY_SECOND)
      else $error("operation started without key pair");
   lock_refuse_a : assert property (
      (lock_q && state_q == unas_pkg::ST_KEY1) |=> !busy_q)
      else $error("locked store started an operation");
   readback_hold_a : assert property (
      $past(state_q) != unas_pkg::ST_LOAD |-> $stable(rdbk_q))
      else $error("readback changed outside a download");

   erase_done_c : cover property (erase_en);
   write_done_c : cover property (prog_en);
   read_done_c : cover property (state_q == unas_pkg::ST_LOAD ##1
                                 crc_err_q);
   refused_c : cover property (refused_q);

endmodule : unas_seq

/* tb/unas_host.sv */
// Host software model: stages data, arms operations, writes unlock keys.
// Assumes the device samples all controls on the rising edge of clk_sys.
`timescale 1ns/100ps
module unas_host (
   input wire logic clk_sys, // System clock
   input wire logic program_in_progress, // Device busy flag
   output logic [unas_pkg::USER_BITS-1:0] stage, // Staging data
   output logic [1:0] sel, // Operation select
   output logic arm, // Program arm
   output logic [unas_pkg::KEY_W-1:0] key, // Unlock key value
   output logic key_wr, // Key strobe
   output logic trig // Reload trigger
);
   localparam int WAIT_MAX = 1000;

   // Quiet controls from time zero
   initial begin
      stage = '0;
      sel = 2'h0;
      arm = 1'b0;
      key = '0;
      key_wr = 1'b0;
      trig = 1'b0;
   end

   task automatic op(input logic [1:0] s, input logic a,
      input logic [unas_pkg::USER_BITS-1:0] d,
      input logic [unas_pkg::KEY_W-1:0] k1,
      input logic [unas_pkg::KEY_W-1:0] k2, input int n);
      @(posedge clk_sys);
      stage <= d;
      sel <= s;
      arm <= a;
      @(posedge clk_sys);
      key_wr <= 1'b1;
      key <= k1;
      if (n >= 2) begin
         @(posedge clk_sys);
         key <= k2;
         // n of 3 drops the arm bit between the keys
         if (n == 3) arm <= 1'b0;
      end
      @(posedge clk_sys);
      key_wr <= 1'b0;
      for (int i = 0; i < WAIT_MAX; i++) begin
         @(posedge clk_sys);
         if (program_in_progress !== 1'b1) break;
      end
      arm <= 1'b0;
   endtask : op

   task automatic read_op();
      @(posedge clk_sys);
      trig <= 1'b1;
      repeat (3) @(posedge clk_sys);
      trig <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask : read_op
endmodule : unas_host

/* tb/testbench.sv */
// Self-checking bench for the user store sequencer with a host model.
// Assumes a shortened operation count; expectations come from a store model.
`timescale 1ns/100ps
module testbench;
   localparam int OPC = 8;
   logic clk_sys;
   logic rst;
   logic [unas_pkg::USER_BITS-1:0] stage;
   logic [1:0] sel;
   logic arm;
   logic [unas_pkg::KEY_W-1:0] key;
   logic key_wr;
   logic trig;
   logic [unas_pkg::USER_BITS-1:0] store_readback_regs;
   logic [unas_pkg::CNT_W-1:0] write_cycle_counter;
   logic [unas_pkg::TRIM_W-1:0] trim_readback;
   logic user_crc_err;
   logic program_in_progress;
   logic store_locked;
   logic op_refused;
   int err_count = 0;
   int checks_done = 0;
   int busy_cycles = 0;
   int refusals = 0;
   int seed = 32'hdbd8;
   int m_cnt = 0;
   int rb_cnt = 0;
   logic [unas_pkg::USER_BITS-1:0] m_data = '0;
   logic [unas_pkg::USER_BITS-1:0] rb_data = '0;

   unas_seq #(.OP_CYCLES_P(OPC)) u_unas_seq (
      .clk_sys(clk_sys), .rst(rst), .store_staging_regs(stage),
      .operation_select(sel), .program_arm(arm), .unlock_key_port(key),
      .unlock_key_wr(key_wr), .reload_trigger(trig),
      .store_readback_regs(store_readback_regs),
      .write_cycle_counter(write_cycle_counter),
      .trim_readback(trim_readback), .user_crc_err(user_crc_err),
      .program_in_progress(program_in_progress),
      .store_locked(store_locked), .op_refused(op_refused));

   unas_host u_host (
      .clk_sys(clk_sys), .program_in_progress(program_in_progress),
      .stage(stage), .sel(sel), .arm(arm), .key(key), .key_wr(key_wr),
      .trig(trig));

   // Free-running 10 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Busy cycles and refusal pulses, sampled before each edge updates
   always @(posedge clk_sys) begin
      if (program_in_progress === 1'b1) busy_cycles++;
      if (op_refused === 1'b1) refusals++;
   end

   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      if (err_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   function automatic logic [unas_pkg::USER_BITS-1:0] rnd();
      logic [127:0] v;
      v = {$random(seed), $random(seed), $random(seed), $random(seed)};
      return v[unas_pkg::USER_BITS-1:0];
   endfunction : rnd

   // Read, then compare with what the store model says was loaded
   task automatic read_check(input logic crc_exp);
      int b;
      b = busy_cycles;
      u_host.read_op();
      rb_data = m_data;
      rb_cnt = m_cnt;
      check(store_readback_regs, rb_data);
      check(write_cycle_counter, rb_cnt);
      check(trim_readback, unas_pkg::TRIM_RESET);
      check(user_crc_err, crc_exp);
      check(busy_cycles - b, 0);
   endtask : read_check

   // One key sequence, armed or not; acceptance worked out from arm, select, keys and count
   task automatic run(input logic [1:0] s, input logic a,
      input logic [unas_pkg::KEY_W-1:0] k1,
      input logic [unas_pkg::KEY_W-1:0] k2, input int n);
      int b;
      int r;
      bit ok;
      logic [unas_pkg::USER_BITS-1:0] d;
      d = rnd();
      b = busy_cycles;
      r = refusals;
      ok = a && s[1] && n == 2 && k1 == unas_pkg::KEY_FIRST &&
         k2 == unas_pkg::KEY_SECOND &&
         !(s == unas_pkg::OP_WRITE && m_cnt >= unas_pkg::MAX_WRITES);
      u_host.op(s, a, d, k1, k2, n);
      repeat (2) @(posedge clk_sys);
      check(busy_cycles - b, ok ? OPC : 0);
      // Disarming between the keys drops the sequence without a pulse
      check(refusals != r, !ok && n != 3);
      check(store_readback_regs, rb_data);
      check(write_cycle_counter, rb_cnt);
      if (ok && s == unas_pkg::OP_ERASE) begin
         m_data = '0;
         m_cnt = 0;
      end
      if (ok && s == unas_pkg::OP_WRITE) begin
         m_data = m_data | d;
         m_cnt++;
      end
   endtask : run

   // Correctly armed and keyed sequence for the given select
   task automatic good(input logic [1:0] s);
      run(s, 1'b1, unas_pkg::KEY_FIRST, unas_pkg::KEY_SECOND, 2);
   endtask : good

   // Watchdog far beyond the roughly 610 cycles of the sequence
   initial begin
      #2000000;
      err_count++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      read_check(1'b0);
      good(unas_pkg::OP_ERASE);
      good(unas_pkg::OP_WRITE);
      read_check(1'b0);
      // second write without erase ORs data
      good(unas_pkg::OP_WRITE);
      read_check(1'b0);
      // reversed, wrong, unarmed, unselected and disarmed sequences
      run(unas_pkg::OP_WRITE, 1'b1, unas_pkg::KEY_SECOND, '0, 1);
      run(unas_pkg::OP_ERASE, 1'b1, unas_pkg::KEY_FIRST, 20'h12345, 2);
      run(unas_pkg::OP_WRITE, 1'b0, unas_pkg::KEY_FIRST, '0, 1);
      run(2'h1, 1'b1, unas_pkg::KEY_FIRST, '0, 1);
      run(unas_pkg::OP_WRITE, 1'b1, unas_pkg::KEY_FIRST,
         unas_pkg::KEY_SECOND, 3);
      read_check(1'b0);
      // forbidden read after erase flags the check code
      good(unas_pkg::OP_ERASE);
      read_check(1'b1);
      // writes up to the ceiling, then one refused
      for (int i = 0; i < 33; i++) begin
         good(unas_pkg::OP_WRITE);
      end
      read_check(1'b0);
      check(store_locked, 1'b0);
      tally_and_finish();
   end
endmodule : testbench
